// ===== bench/sysctl_assertions.sv
// Checker for the link between the system control block and its controller.
`timescale 1ns/10ps
module sysctl_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reg_req,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reset_req,
   input wire logic deep_sel,
   input wire logic low_power
);
   // ************************************************************
   // Link properties
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_app, wr_app, wr_low, rd_low;
   assign rd_app = reg_req && !reg_ack && !reg_wr && reg_addr == sysctl_pkg::APP_CTRL_OFS;
   assign wr_app = reg_req && !reg_ack && reg_wr && reg_addr == sysctl_pkg::APP_CTRL_OFS;
   assign wr_low = reg_req && !reg_ack && reg_wr && reg_addr == sysctl_pkg::LOW_POWER_OFS;
   assign rd_low = reg_req && !reg_ack && !reg_wr && reg_addr == sysctl_pkg::LOW_POWER_OFS;
   ack_follows_req_a: assert property (reg_req && !reg_ack |=> reg_ack)
      else $error("link ack missing after request");
   ack_pulse_a: assert property (reg_ack |=> !reg_ack)
      else $error("link ack longer than one cycle");
   key_readback_a: assert property (rd_app |=> reg_rdata[31:16] == 16'hFA05)
      else $error("key status not in upper halfword");
   fixed_zero_a: assert property (rd_app |=> reg_rdata[15:11] == 5'h00 && reg_rdata[7:0] == 8'h00)
      else $error("fixed zero bits read nonzero");
   reset_set_a: assert property (wr_app && reg_wdata[31:16] == 16'h05FA && reg_wdata[2] |-> ##[1:2] reset_req)
      else $error("reset request not raised");
   reset_hold_a: assert property (reset_req |=> reset_req)
      else $error("reset request dropped");
   bad_key_a: assert property (wr_app && reg_wdata[31:16] != 16'h05FA && !reset_req |=> !reset_req [*2])
      else $error("write with wrong key took effect");
   deep_follow_a: assert property (wr_low |=> ##1 deep_sel == $past(reg_wdata[2], 2))
      else $error("deep select does not follow write");
   deep_stable_a: assert property (!wr_low |=> $stable(deep_sel))
      else $error("deep select changed without a write");
   low_zero_a: assert property (rd_low |=> reg_rdata[31:5] == 27'h0 && !reg_rdata[3] && !reg_rdata[0])
      else $error("reserved low power bits read nonzero");
endmodule

// ===== bench/tb.sv
// Self-checking bench: controller and system control block joined by their link.
`timescale 1ns/10ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic sys_reset_req, deep_sleep_sel, preempt, event_latched;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] new_priority, active_priority, group_mask, m;
   logic [6:0] ev;
   logic [2:0] cur_split, s;
   logic [15:0] key;
   logic ins;
   int fails, n_checks, cycles;
   sysctl_if link();
   sysctl_dev sysctl_dev_i (.pclk(pclk), .presetn(presetn), .link(link),
      .new_priority(new_priority), .active_priority(active_priority),
      .wait_for_event_instr(ev[0]), .send_event_instr(ev[1]), .ext_event(ev[2]),
      .event_pend(ev[3]), .irq_pend_enabled(ev[4]), .irq_pend_disabled(ev[5]),
      .handler_to_thread(ev[6]), .preempt(preempt), .group_mask(group_mask),
      .event_latched(event_latched));
   sysctl_host sysctl_host_i (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
      .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sys_reset_req(sys_reset_req),
      .deep_sleep_sel(deep_sleep_sel));
   sysctl_checker sysctl_checker_i (.pclk(pclk), .presetn(presetn), .reg_req(link.reg_req),
      .reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
      .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .reset_req(link.reset_req),
      .deep_sel(link.deep_sel), .low_power(link.low_power));
   // ************************************************************
   // Helpers
   // ************************************************************
   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 10000) begin
         fails++;
         summarize();
      end
   end
   function automatic logic [31:0] app_exp(input logic [2:0] sp);
      return {16'hFA05, 5'h00, sp, 8'h00};
   endfunction
   // Split values 0 to 3 keep all four bits as group priority.
   function automatic logic [3:0] mask_exp(input logic [2:0] sp);
      return sp[2] ? 4'(4'hF << (sp - 3'h3)) : 4'hF;
   endfunction
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // The request is held until pready is seen high at a rising edge.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      chk("pslverr", 32'h0, {31'h0, pslverr});
      psel <= 0;
      penable <= 0;
   endtask
   task dev_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      apb(1, sysctl_pkg::CTL_ADDR_OFS, {24'h0, a});
      if (wr)
         apb(1, sysctl_pkg::CTL_WDATA_OFS, d);
      apb(1, sysctl_pkg::CTL_CMD_OFS, wr ? {29'h0, ins, 2'h3} : 32'h1);
      for (int i = 0; i < 20; i++) begin
         apb(0, sysctl_pkg::CTL_STATUS_OFS, 32'h0);
         if (q[0] === 1'b0)
            break;
      end
      if (!wr)
         apb(0, sysctl_pkg::CTL_RDATA_OFS, 32'h0);
   endtask
   task lp(input int b, input logic exp);
      @(posedge pclk);
      ev[b] <= 1;
      @(posedge pclk);
      ev[b] <= 0;
      repeat (2) @(posedge pclk);
      #1;
      chk("low_power", {31'h0, exp}, {31'h0, link.low_power});
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      new_priority = 0; active_priority = 0; ev = 0; fails = 0; n_checks = 0; cycles = 0;
      ins = 0;
      void'($urandom(60));
      repeat (5) @(posedge pclk);
      presetn <= 1;
      dev_acc(0, sysctl_pkg::APP_CTRL_OFS, 0);
      chk("app_ctrl reset", 32'hFA050000, q);
      dev_acc(0, sysctl_pkg::LOW_POWER_OFS, 0);
      chk("low_power_control reset", 32'h0, q);
      lp(6, 0);
      cur_split = 0;
      for (int i = 0; i < 12; i++) begin
         s = 3'($urandom);
         key = (i == 0) ? 16'hFA05 : (i % 3 != 0) ? 16'h05FA : 16'h05FA ^ 16'($urandom_range(1, 65535));
         dev_acc(1, sysctl_pkg::APP_CTRL_OFS, {key, 5'h00, s, 8'h00});
         if (key == 16'h05FA)
            cur_split = s;
         dev_acc(0, sysctl_pkg::APP_CTRL_OFS, 0);
         chk("app_ctrl", app_exp(cur_split), q);
      end
      ins = 1;
      dev_acc(1, sysctl_pkg::APP_CTRL_OFS, 32'h00000500);
      ins = 0;
      dev_acc(0, sysctl_pkg::APP_CTRL_OFS, 0);
      chk("app_ctrl key insert", app_exp(3'h5), q);
      for (int sp = 0; sp < 8; sp++) begin
         dev_acc(1, sysctl_pkg::APP_CTRL_OFS, {16'h05FA, 5'h00, 3'(sp), 8'h00});
         m = mask_exp(3'(sp));
         for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            new_priority <= 4'($urandom);
            active_priority <= 4'($urandom);
            repeat (2) @(posedge pclk);
            #1;
            chk("group_mask", {28'h0, m}, {28'h0, group_mask});
            chk("preempt", 32'((new_priority & m) < (active_priority & m)), {31'h0, preempt});
         end
      end
      dev_acc(1, sysctl_pkg::LOW_POWER_OFS, 32'h6);
      dev_acc(0, sysctl_pkg::LOW_POWER_OFS, 0);
      chk("low_power_control", 32'h6, q);
      chk("deep_sleep_sel", 32'h1, {31'h0, deep_sleep_sel});
      for (int b = 1; b < 5; b++) begin
         lp(0, 1);
         lp(5, 1);
         lp(b, 0);
      end
      lp(6, 1);
      lp(2, 0);
      dev_acc(1, sysctl_pkg::LOW_POWER_OFS, 32'h12);
      dev_acc(0, sysctl_pkg::LOW_POWER_OFS, 0);
      chk("low_power_control", 32'h12, q);
      chk("deep_sel", 32'h0, {31'h0, link.deep_sel});
      lp(0, 1);
      lp(5, 0);
      lp(3, 0);
      chk("event_latched", 32'h1, {31'h0, event_latched});
      lp(0, 0);
      chk("event_latched", 32'h0, {31'h0, event_latched});
      dev_acc(1, sysctl_pkg::APP_CTRL_OFS, 32'h12340004);
      chk("sys_reset_req", 32'h0, {31'h0, sys_reset_req});
      dev_acc(1, sysctl_pkg::APP_CTRL_OFS, 32'h05FA0004);
      repeat (50) @(posedge pclk);
      #1;
      chk("reset_req", 32'h1, {31'h0, link.reset_req});
      chk("sys_reset_req", 32'h1, {31'h0, sys_reset_req});
      apb(0, sysctl_pkg::CTL_STATUS_OFS, 32'h0);
      chk("status reset bit", 32'h1, {31'h0, q[1]});
      dev_acc(0, sysctl_pkg::APP_CTRL_OFS, 0);
      chk("app_ctrl", app_exp(3'h0), q);
      apb(0, 8'h40, 32'h0);
      chk("unmapped apb", 32'h0, q);
      dev_acc(0, 8'h20, 0);
      chk("unmapped device", 32'h0, q);
      presetn <= 0;
      repeat (5) @(posedge pclk);
      presetn <= 1;
      dev_acc(0, sysctl_pkg::APP_CTRL_OFS, 0);
      chk("app_ctrl reset", 32'hFA050000, q);
      chk("reset_req", 32'h0, {31'h0, link.reset_req});
      summarize();
   end
endmodule

// ===== rtl/sysctl_dev.sv
// System control block: keyed reset/priority register and low-power control register.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module sysctl_dev (
   input wire logic pclk,
   input wire logic presetn,
   sysctl_if.dev link,
   input wire logic [3:0] new_priority,
   input wire logic [3:0] active_priority,
   input wire logic wait_for_event_instr,
   input wire logic send_event_instr,
   input wire logic ext_event,
   input wire logic event_pend,
   input wire logic irq_pend_enabled,
   input wire logic irq_pend_disabled,
   input wire logic handler_to_thread,
   output logic preempt,
   output logic [3:0] group_mask,
   output logic event_latched
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [2:0] split;
      logic ev_on_pend;
      logic deep;
      logic sleep_exit;
      logic rst_req;
      logic [31:0] rdata;
      logic ack;
      logic ev_latch;
      logic waiting;
      logic preempt;
      logic [3:0] mask;
   } dev_state_s;

   dev_state_s st_r;
   dev_state_s st_nxt;

   logic key_ok;
   logic wr_take;
   logic rd_take;
   logic wake;
   logic [3:0] mask_c;
   logic [31:0] app_rd;
   logic [31:0] lp_rd;

   // ************************************************************
   // Combinational next state
   // ************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      rd_take = link.reg_req && !link.reg_wr && !st_r.ack;
      wr_take = link.reg_req && link.reg_wr && !st_r.ack;
      // Only the exact unlock value opens the register; the readback key does not.
      // The check is made on the word exactly as the host presents it.
      key_ok = (link.reg_wdata[sysctl_pkg::KEY_MSB:sysctl_pkg::KEY_LSB]
                == sysctl_pkg::WRITE_UNLOCK_KEY);

      // Key status, byte order zero, split, and debug/reset bits zero.
      app_rd = 32'h00000000;
      app_rd[sysctl_pkg::KEY_MSB:sysctl_pkg::KEY_LSB] = sysctl_pkg::UNLOCK_KEY_READBACK;
      app_rd[sysctl_pkg::BYTE_ORDER_BIT] = 1'b0;
      app_rd[sysctl_pkg::SPLIT_MSB:sysctl_pkg::SPLIT_LSB] = st_r.split;
      app_rd[sysctl_pkg::SYS_RESET_REQ_BIT] = 1'b0;
      app_rd[sysctl_pkg::DEBUG_CLEAR_ACTIVE_BIT] = 1'b0;
      app_rd[sysctl_pkg::DEBUG_LOCAL_RESET_BIT] = 1'b0;

      lp_rd = 32'h00000000;
      lp_rd[sysctl_pkg::EVENT_ON_PENDING_BIT] = st_r.ev_on_pend;
      lp_rd[sysctl_pkg::DEEP_SELECT_BIT] = st_r.deep;
      lp_rd[sysctl_pkg::SLEEP_AFTER_HANDLER_BIT] = st_r.sleep_exit;

      // The acknowledge is a one-cycle pulse. A request still high in that cycle is
      // not taken again, so the host may drop it at the edge that sees the pulse.
      // Every request is answered, refused writes included, so the host never stalls.
      if (link.reg_req && !st_r.ack) begin
         st_nxt.ack = 1'b1;
      end

      // Unmapped offsets read as zero.
      if (rd_take) begin
         case (link.reg_addr)
            sysctl_pkg::APP_CTRL_OFS: st_nxt.rdata = app_rd;
            sysctl_pkg::LOW_POWER_OFS: st_nxt.rdata = lp_rd;
            default: st_nxt.rdata = 32'h00000000;
         endcase
      end

      // Only the split field and the reset request take write data; the other
      // fields of the keyed register are fixed.
      if (wr_take) begin
         case (link.reg_addr)
            sysctl_pkg::APP_CTRL_OFS: begin
               if (key_ok) begin
                  st_nxt.split = link.reg_wdata[sysctl_pkg::SPLIT_MSB:sysctl_pkg::SPLIT_LSB];
                  if (link.reg_wdata[sysctl_pkg::SYS_RESET_REQ_BIT]) begin
                     st_nxt.rst_req = 1'b1;
                  end
               end
            end
            sysctl_pkg::LOW_POWER_OFS: begin
               st_nxt.ev_on_pend = link.reg_wdata[sysctl_pkg::EVENT_ON_PENDING_BIT];
               st_nxt.deep = link.reg_wdata[sysctl_pkg::DEEP_SELECT_BIT];
               st_nxt.sleep_exit = link.reg_wdata[sysctl_pkg::SLEEP_AFTER_HANDLER_BIT];
            end
            default: begin
            end
         endcase
      end

      // ************************************************************
      // Priority split and wake logic
      // ************************************************************
      // Binary point: bits of the priority that count as group.
      case (st_r.split)
         3'h4: mask_c = 4'hE;
         3'h5: mask_c = 4'hC;
         3'h6: mask_c = 4'h8;
         3'h7: mask_c = 4'h0;
         default: mask_c = 4'hF;
      endcase
      st_nxt.mask = mask_c;
      // With the whole value taken as subpriority nothing ever preempts.
      st_nxt.preempt = (new_priority & mask_c) < (active_priority & mask_c);

      // Wake sources; disabled interrupts count only with event-on-pending set.
      wake = event_pend || irq_pend_enabled
             || (st_r.ev_on_pend && irq_pend_disabled)
             || send_event_instr || ext_event;

      // Sleep-on-exit shares the wait flag, so the same wake sources end it.
      // The wait flag is the low-power indication seen by the power logic;
      // its depth comes from the deep select bit alone.
      if (st_r.waiting) begin
         if (wake) begin
            st_nxt.waiting = 1'b0;
         end
      end else if (wait_for_event_instr) begin
         // A latched or simultaneous event lets the wait finish at once.
         if (st_r.ev_latch || wake) begin
            st_nxt.ev_latch = 1'b0;
         end else begin
            st_nxt.waiting = 1'b1;
         end
      end else begin
         if (wake) begin
            st_nxt.ev_latch = 1'b1;
         end
         if (handler_to_thread && st_r.sleep_exit) begin
            st_nxt.waiting = 1'b1;
         end
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Reset leaves the split at its all-group setting and clears the request.
         st_r.split <= sysctl_pkg::SPLIT_RESET;
         st_r.ev_on_pend <= sysctl_pkg::LOW_POWER_RESET[sysctl_pkg::EVENT_ON_PENDING_BIT];
         st_r.deep <= sysctl_pkg::LOW_POWER_RESET[sysctl_pkg::DEEP_SELECT_BIT];
         st_r.sleep_exit <= sysctl_pkg::LOW_POWER_RESET[sysctl_pkg::SLEEP_AFTER_HANDLER_BIT];
         st_r.rst_req <= 1'b0;
         st_r.rdata <= 32'h00000000;
         st_r.ack <= 1'b0;
         st_r.ev_latch <= 1'b0;
         st_r.waiting <= 1'b0;
         st_r.preempt <= 1'b0;
         st_r.mask <= 4'hF;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // The request is only ever set here; only presetn clears it.
   assign link.reset_req = st_r.rst_req;
   assign link.reg_rdata = st_r.rdata;
   assign link.reg_ack = st_r.ack;
   assign link.deep_sel = st_r.deep;
   assign link.low_power = st_r.waiting;
   assign preempt = st_r.preempt;
   assign group_mask = st_r.mask;
   assign event_latched = st_r.ev_latch;

endmodule

// ===== rtl/sysctl_host.sv
// Controller: APB slave that issues register accesses and reacts to reset and sleep signals.
`timescale 1ns/10ps
module sysctl_host (
   input wire logic pclk,
   input wire logic presetn,
   sysctl_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic sys_reset_req,
   output logic deep_sleep_sel
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      sysctl_pkg::host_state_e fsm;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic wr;
      logic req;
      logic [31:0] prdata;
      logic pready;
      logic sys_rst;
      logic deep;
   } host_state_s;

   host_state_s st_r;
   host_state_s st_nxt;
   logic apb_acc;
   logic [31:0] status;
   logic [31:0] masked;

   always_comb begin
      st_nxt = st_r;
      st_nxt.pready = 1'b0;
      apb_acc = psel && penable && !st_r.pready;
      status = 32'h00000000;
      status[sysctl_pkg::ST_BUSY_BIT] = (st_r.fsm == sysctl_pkg::HOST_WAIT);
      status[sysctl_pkg::ST_RESET_REQ_BIT] = link.reset_req;
      status[sysctl_pkg::ST_DEEP_BIT] = link.deep_sel;
      status[sysctl_pkg::ST_LOW_POWER_BIT] = link.low_power;

      // Reserved and debug bits are forced to zero before they reach the device.
      // The word comes from the data register; of the command bits only the insert-key bit changes it, by putting in the unlock key.
      if (st_r.addr == sysctl_pkg::APP_CTRL_OFS) begin
         masked = st_r.wdata & sysctl_pkg::APP_CTRL_WR_MASK;
         if (pwdata[sysctl_pkg::CMD_INSERT_KEY_BIT]) begin
            masked[sysctl_pkg::KEY_MSB:sysctl_pkg::KEY_LSB] = sysctl_pkg::WRITE_UNLOCK_KEY;
         end
      end else begin
         masked = st_r.wdata & sysctl_pkg::LOW_POWER_WR_MASK;
      end

      if (apb_acc) begin
         st_nxt.pready = 1'b1;
         if (pwrite) begin
            case (paddr)
               sysctl_pkg::CTL_ADDR_OFS: st_nxt.addr = pwdata[7:0];
               sysctl_pkg::CTL_WDATA_OFS: st_nxt.wdata = pwdata;
               default: begin
               end
            endcase
         end else begin
            case (paddr)
               sysctl_pkg::CTL_ADDR_OFS: st_nxt.prdata = {24'h000000, st_r.addr};
               sysctl_pkg::CTL_WDATA_OFS: st_nxt.prdata = st_r.wdata;
               sysctl_pkg::CTL_STATUS_OFS: st_nxt.prdata = status;
               sysctl_pkg::CTL_RDATA_OFS: st_nxt.prdata = st_r.rdata;
               default: st_nxt.prdata = 32'h00000000;
            endcase
         end
      end

      case (st_r.fsm)
         sysctl_pkg::HOST_IDLE: begin
            if (apb_acc && pwrite && paddr == sysctl_pkg::CTL_CMD_OFS
                && pwdata[sysctl_pkg::CMD_GO_BIT]) begin
               st_nxt.fsm = sysctl_pkg::HOST_WAIT;
               st_nxt.req = 1'b1;
               st_nxt.wr = pwdata[sysctl_pkg::CMD_WRITE_BIT];
               st_nxt.wdata = pwdata[sysctl_pkg::CMD_WRITE_BIT] ? masked : st_r.wdata;
            end
         end
         sysctl_pkg::HOST_WAIT: begin
            if (link.reg_ack) begin
               st_nxt.fsm = sysctl_pkg::HOST_IDLE;
               st_nxt.req = 1'b0;
               if (!st_r.wr) begin
                  st_nxt.rdata = link.reg_rdata;
               end
            end
         end
         default: st_nxt.fsm = sysctl_pkg::HOST_IDLE;
      endcase

      // Passed on to the system reset logic, which spares debug.
      st_nxt.sys_rst = link.reset_req;
      st_nxt.deep = link.deep_sel;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.reg_req = st_r.req;
   assign link.reg_wr = st_r.wr;
   assign link.reg_addr = st_r.addr;
   assign link.reg_wdata = st_r.wdata;
   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = 1'b0;
   assign sys_reset_req = st_r.sys_rst;
   assign deep_sleep_sel = st_r.deep;

endmodule

// ===== rtl/sysctl_if.sv
// Link between the system control block and its controller.
`timescale 1ns/10ps
interface sysctl_if;
   logic reg_req;
   logic reg_wr;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic reg_ack;
   logic reset_req;
   logic deep_sel;
   logic low_power;

   modport dev (
      input reg_req, reg_wr, reg_addr, reg_wdata,
      output reg_rdata, reg_ack, reset_req, deep_sel, low_power
   );
   modport host (
      output reg_req, reg_wr, reg_addr, reg_wdata,
      input reg_rdata, reg_ack, reset_req, deep_sel, low_power
   );
endinterface

// ===== rtl/sysctl_pkg.sv
// Shared constants for the reset, priority and sleep control block and its controller.
package sysctl_pkg;

   // ************************************************************
   // Device register map
   // ************************************************************
   localparam logic [7:0] APP_CTRL_OFS = 8'h0C;
   localparam logic [7:0] LOW_POWER_OFS = 8'h10;
   localparam logic [31:0] APP_CTRL_RESET = 32'hFA050000;
   localparam logic [31:0] LOW_POWER_RESET = 32'h00000000;

   localparam logic [15:0] WRITE_UNLOCK_KEY = 16'h05FA;
   localparam logic [15:0] UNLOCK_KEY_READBACK = 16'hFA05;
   localparam int KEY_MSB = 31;
   localparam int KEY_LSB = 16;
   localparam int BYTE_ORDER_BIT = 15;
   localparam int SPLIT_MSB = 10;
   localparam int SPLIT_LSB = 8;
   localparam int SYS_RESET_REQ_BIT = 2;
   localparam int DEBUG_CLEAR_ACTIVE_BIT = 1;
   localparam int DEBUG_LOCAL_RESET_BIT = 0;
   localparam logic [31:0] APP_CTRL_WR_MASK = 32'hFFFF0704;

   localparam int EVENT_ON_PENDING_BIT = 4;
   localparam int DEEP_SELECT_BIT = 2;
   localparam int SLEEP_AFTER_HANDLER_BIT = 1;
   localparam logic [31:0] LOW_POWER_WR_MASK = 32'h00000016;

   localparam logic [2:0] SPLIT_RESET = 3'h0;

   // ************************************************************
   // Controller register map
   // ************************************************************
   localparam logic [7:0] CTL_ADDR_OFS = 8'h00;
   localparam logic [7:0] CTL_WDATA_OFS = 8'h04;
   localparam logic [7:0] CTL_CMD_OFS = 8'h08;
   localparam logic [7:0] CTL_STATUS_OFS = 8'h0C;
   localparam logic [7:0] CTL_RDATA_OFS = 8'h10;
   localparam int CMD_GO_BIT = 0;
   localparam int CMD_WRITE_BIT = 1;
   localparam int CMD_INSERT_KEY_BIT = 2;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_RESET_REQ_BIT = 1;
   localparam int ST_DEEP_BIT = 2;
   localparam int ST_LOW_POWER_BIT = 3;

   typedef enum logic [0:0] {
      HOST_IDLE = 1'b0,
      HOST_WAIT = 1'b1
   } host_state_e;

endpackage
